/* rtl/brownout_pkg.sv */
// Purpose: shared constants and types for the brown-out detector control block
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   register offsets and reset values used by design and bench
//
// Summary of operation
// (R1) select 00 keeps the detector powered all the time
// (R2) select 01 powers the detector once every 1.6 ms
// (R3) select 10 powers the detector once every 6.4 ms
// (R4) select 11 powers the detector once every 25.6 ms
// (R5) fast clock source in normal mode: filter counts 32 system clocks
// (R6) any other setup: filter counts 2 low-speed oscillator ticks
// (R7) in power-down the filter always counts 2 low-speed oscillator ticks
// (R8) filter enable 0 bypasses filter, 1 applies it; reset value is 1
// (R9) control register writes land only right after a timed unlock sequence
// (R10) accepted event sets flag; irq needs flag, irq enable and global enable
// (R11) filtered event needs detector held the full count; release restarts count
package brownout_pkg;
    // register map
    localparam logic [7:0] CTRL_OFFSET      = 8'hab;
    localparam logic [7:0] UNLOCK_OFFSET    = 8'hc0;
    localparam logic [7:0] STATUS_OFFSET    = 8'hc1;
    // control register fields
    localparam int         FLT_BIT          = 0;
    localparam int         LP_LSB           = 1;
    localparam logic [1:0] LP_NORMAL        = 2'h0;
    localparam logic [1:0] LP_MODE1         = 2'h1;
    localparam logic [1:0] LP_MODE2         = 2'h2;
    localparam logic [1:0] LP_MODE3         = 2'h3;
    localparam logic [1:0] LP_RESET         = 2'h0;
    localparam logic       FLT_RESET        = 1'h1;
    // status register fields
    localparam int         FLAG_BIT         = 0;
    localparam int         IRQ_EN_BIT       = 1;
    localparam int         GLOBAL_EN_BIT    = 2;
    localparam int         UNLOCK_OPEN_BIT  = 0;
    // timed unlock sequence
    localparam logic [7:0] UNLOCK_KEY1      = 8'haa;
    localparam logic [7:0] UNLOCK_KEY2      = 8'h55;
    localparam logic [2:0] UNLOCK_WINDOW    = 3'h4;
    // timing
    localparam int         MCLK_PERIOD_NS   = 4;
    localparam int         LP_BASE_NS       = 1600000;
    localparam int         LP_BASE_CYCLES   = LP_BASE_NS / MCLK_PERIOD_NS;
    localparam int         LOW_SPEED_INTERNAL_OSC_PERIOD_NS   = 100000;
    localparam int         LOW_SPEED_INTERNAL_OSC_CYCLES      = LOW_SPEED_INTERNAL_OSC_PERIOD_NS / MCLK_PERIOD_NS;
    localparam logic [5:0] FAST_FILTER_CNT  = 6'h20;
    localparam logic [5:0] SLOW_FILTER_CNT  = 6'h02;
    localparam logic [1:0] WAKE_LOW_SPEED_INTERNAL_OSC_TICKS  = 2'h3;
    localparam logic [3:0] MODE2_MULT_LAST  = 4'h3;
    localparam logic [3:0] MODE3_MULT_LAST  = 4'hf;

    typedef enum logic {
        PWR_OFF = 1'b0,
        PWR_ON  = 1'b1
    } pwr_state_type;

    typedef struct packed {
        logic [1:0]    lpSel;
        logic          fltEn;
        logic          keyStage;
        logic [2:0]    unlockLeft;
        logic          flag;
        logic          irqEn;
        logic          globalEn;
        logic [7:0]    rdData;
        logic [3:0]    periodMult;
        pwr_state_type pwr;
        logic [1:0]    wakeLeft;
        logic [5:0]    fltCnt;
        logic          accepted;
        logic          evtPulse;
    } ctrl_state_type;
endpackage : brownout_pkg

/* rtl/periodic_tick.sv */
// Purpose: free-running divider giving a one-cycle enable pulse
// Assumes: PERIOD of at least 2 cycles
// Notes:   pulse appears on the last cycle of each period
`timescale 1ns/10ps
module periodic_tick #(
    parameter int PERIOD = 2
) (
    input  wire logic mclk,
    input  wire logic reset,
    output logic      tick
);
    localparam int CW = (PERIOD > 2) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count_reg;

    // wraps at LAST so the pulse spacing is exactly PERIOD cycles
    always_ff @(posedge mclk) begin
        if (reset) begin
            count_reg <= '0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign tick = (count_reg == LAST);
endmodule : periodic_tick

/* rtl/brownout_detect_control.sv */
// Purpose: digital control of the brown-out detector: duty cycle, noise filter, flag
// Assumes: detector output and clock-source status are synchronous to mclk
// Notes:   low-speed oscillator is modelled as an enable pulse divided from mclk
//          a locked control write is dropped with no sign at the ports, so
//          software must read the register back to learn whether it landed
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module brownout_detect_control
    import brownout_pkg::*;
#(
    parameter int LP_BASE_PERIOD = brownout_pkg::LP_BASE_CYCLES,
    parameter int LOW_SPEED_INTERNAL_OSC_PERIOD    = brownout_pkg::LOW_SPEED_INTERNAL_OSC_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       detectorOut,
    input  wire logic       fastClockSource,
    input  wire logic       powerDown,
    output logic            detectorEnable,
    output logic            filterOnSystemClock,
    output logic            brownoutEvent,
    output logic            brownoutFlag,
    output logic            brownoutIrq
);
    import brownout_pkg::*;

    ctrl_state_type s_reg;
    ctrl_state_type s_next;
    logic           lircTick;
    logic           baseTick;

    // low-speed oscillator rate as an enable pulse
    periodic_tick #(
        .PERIOD (LOW_SPEED_INTERNAL_OSC_PERIOD)
    ) low_speed_internal_osc_div (
        .mclk  (mclk),
        .reset (reset),
        .tick  (lircTick)
    );

    // 1.6 ms base period; longer periods are multiples of it
    periodic_tick #(
        .PERIOD (LP_BASE_PERIOD)
    ) base_div (
        .mclk  (mclk),
        .reset (reset),
        .tick  (baseTick)
    );

    logic       useFast;
    logic       sampling;
    logic       step;
    logic [5:0] target;
    logic       periodDone;
    logic       unlocked;
    logic       ctrlWrite;
    logic       statusWrite;
    logic       unlockWrite;

    // strobe aimed at one register; every register decodes its write strobe this way
    function automatic logic reg_hit(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] offset);
        return strobe && (addr == offset);
    endfunction : reg_hit

    // filter clock choice; power-down forces the slow count
    always_comb begin
        useFast    = fastClockSource && (s_reg.lpSel == LP_NORMAL) && !powerDown; // R5 R6 R7
        target     = useFast ? FAST_FILTER_CNT : SLOW_FILTER_CNT; // R5 R6
        step       = useFast ? 1'b1 : lircTick; // R6 R7
        // normal mode keeps the detector on; otherwise only during a wake
        sampling   = (s_reg.lpSel == LP_NORMAL) || (s_reg.pwr == PWR_ON); // R1
        unlocked   = (s_reg.unlockLeft != 3'h0);
        ctrlWrite  = reg_hit(regWrite, regAddr, CTRL_OFFSET);
        statusWrite = reg_hit(regWrite, regAddr, STATUS_OFFSET);
        unlockWrite = reg_hit(regWrite, regAddr, UNLOCK_OFFSET);
    end

    // period end for the selected low-power mode
    // mode2 and mode3 reuse the free-running multiplier, so the first wake
    // after a mode change may come early; later ones keep the full period
    always_comb begin
        unique case (s_reg.lpSel)
            LP_NORMAL: periodDone = 1'b0; // R1
            LP_MODE1:  periodDone = baseTick; // R2
            LP_MODE2:  periodDone = baseTick && (s_reg.periodMult[1:0] == MODE2_MULT_LAST[1:0]); // R3
            LP_MODE3:  periodDone = baseTick && (s_reg.periodMult == MODE3_MULT_LAST); // R4
        endcase
    end

    // next-state logic for the whole block
    always_comb begin
        s_next          = s_reg;
        s_next.evtPulse = 1'b0;

        // timed unlock: key1 then key2 opens a short window for one write
        if (unlocked) begin
            s_next.unlockLeft = s_reg.unlockLeft - 3'h1;
        end
        if (unlockWrite) begin
            if (regWrData == UNLOCK_KEY1) begin
                s_next.keyStage = 1'b1;
            end else if (s_reg.keyStage && (regWrData == UNLOCK_KEY2)) begin
                s_next.keyStage   = 1'b0;
                s_next.unlockLeft = UNLOCK_WINDOW; // R9
            end else begin
                s_next.keyStage = 1'b0;
            end
        end else if (regWrite) begin
            s_next.keyStage = 1'b0; // any other write breaks the key sequence
        end

        // protected control write; a locked write is silently dropped
        if (ctrlWrite && unlocked) begin
            s_next.lpSel      = regWrData[LP_LSB +: 2]; // R9
            s_next.fltEn      = regWrData[FLT_BIT]; // R9
            s_next.unlockLeft = 3'h0; // window is spent by one write
        end

        // status: write one clears the flag, enables are plain bits
        if (statusWrite) begin
            s_next.irqEn    = regWrData[IRQ_EN_BIT];
            s_next.globalEn = regWrData[GLOBAL_EN_BIT];
            if (regWrData[FLAG_BIT]) begin
                s_next.flag = 1'b0;
            end
        end

        // duty cycling: base ticks counted to reach 6.4 ms and 25.6 ms
        if (baseTick) begin
            s_next.periodMult = s_reg.periodMult + 4'h1;
        end
        if (s_reg.lpSel == LP_NORMAL) begin
            s_next.pwr = PWR_OFF; // R1
        end else begin
            unique case (s_reg.pwr)
                PWR_OFF: begin
                    if (periodDone) begin
                        s_next.pwr      = PWR_ON; // R2 R3 R4
                        s_next.wakeLeft = WAKE_LOW_SPEED_INTERNAL_OSC_TICKS;
                    end
                end
                PWR_ON: begin
                    // stays on long enough for the two-tick filter to resolve
                    if (lircTick) begin
                        s_next.wakeLeft = s_reg.wakeLeft - 2'h1;
                        if (s_reg.wakeLeft == 2'h1) begin
                            s_next.pwr = PWR_OFF;
                        end
                    end
                end
            endcase
        end

        // noise filter; one accepted event per assertion of the detector
        // count clears on any gap so a train of short glitches never adds up
        if (!sampling || !detectorOut) begin
            s_next.fltCnt   = 6'h0; // R11
            s_next.accepted = 1'b0;
        end else if (!s_reg.accepted) begin
            // power-down keeps the filter in even with the bypass bit clear
            if (!s_reg.fltEn && !powerDown) begin
                s_next.accepted = 1'b1; // R8 R7
                s_next.evtPulse = 1'b1;
            end else if (step) begin
                if (s_reg.fltCnt + 6'h1 >= target) begin
                    s_next.accepted = 1'b1; // R11
                    s_next.evtPulse = 1'b1;
                    s_next.fltCnt   = 6'h0;
                end else begin
                    s_next.fltCnt = s_reg.fltCnt + 6'h1; // R11
                end
            end
        end
        // set wins over a clear in the same cycle
        if (s_next.evtPulse) begin
            s_next.flag = 1'b1; // R10
        end

        // read data stands one cycle after the strobe only
        s_next.rdData = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                CTRL_OFFSET: begin
                    s_next.rdData[LP_LSB +: 2] = s_reg.lpSel;
                    s_next.rdData[FLT_BIT]     = s_reg.fltEn;
                end
                STATUS_OFFSET: begin
                    s_next.rdData[FLAG_BIT]      = s_reg.flag;
                    s_next.rdData[IRQ_EN_BIT]    = s_reg.irqEn;
                    s_next.rdData[GLOBAL_EN_BIT] = s_reg.globalEn;
                end
                UNLOCK_OFFSET: s_next.rdData[UNLOCK_OPEN_BIT] = unlocked;
                default:       s_next.rdData = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // single state register; filter enable comes up set
    always_ff @(posedge mclk) begin
        if (reset) begin
            // the whole struct clears so no field starts unknown
            s_reg            <= '0;
            s_reg.lpSel      <= LP_RESET;
            s_reg.fltEn      <= FLT_RESET; // R8
            s_reg.pwr        <= PWR_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register or from plain gating of it; filterOnSystemClock also gates fastClockSource and powerDown
    assign regRdData           = s_reg.rdData;
    assign detectorEnable      = sampling; // R1 R2 R3 R4
    assign filterOnSystemClock = useFast;
    assign brownoutEvent       = s_reg.evtPulse;
    assign brownoutFlag        = s_reg.flag;
    assign brownoutIrq         = s_reg.flag && s_reg.irqEn && s_reg.globalEn; // R10
endmodule : brownout_detect_control

/* test/brownout_analog_model.sv */
// Purpose: model of the analog detector behind the control block
// Assumes: supply level comes from the bench
// Notes:   an unpowered comparator output toggles, it never holds a value
`timescale 1ns/10ps
module brownout_analog_model (
    input  wire logic mclk,
    input  wire logic detectorEnable,
    input  wire logic supplyLow,
    output logic      detectorOut
);
    logic scramble_reg = 1'b0;
    // scramble while off so an ungated filter would be caught
    always @(posedge mclk) scramble_reg <= !scramble_reg;
    assign detectorOut = detectorEnable ? supplyLow : scramble_reg;
endmodule : brownout_analog_model

/* test/brownout_detect_control_checker.sv */
// Purpose: port assertions for the brown-out control block
// Assumes: one clock, synchronous reset
// Notes:   off-time bound is sixteen base periods, the slowest mode
`timescale 1ns/10ps
module brownout_detect_control_checker #(
    parameter int LP_BASE_PERIOD = 40,
    parameter int LOW_SPEED_INTERNAL_OSC_PERIOD    = 5
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic detectorOut,
    input wire logic fastClockSource,
    input wire logic powerDown,
    input wire logic detectorEnable,
    input wire logic filterOnSystemClock,
    input wire logic brownoutEvent,
    input wire logic brownoutFlag,
    input wire logic brownoutIrq
);
    localparam int OFF_MAX = 16 * LP_BASE_PERIOD;
    logic [31:0] offCnt_reg;
    // off span counted in cycles; real periods far outgrow any delay range
    always_ff @(posedge mclk) begin
        if (reset || detectorEnable) begin
            offCnt_reg <= 32'h0;
        end else begin
            offCnt_reg <= offCnt_reg + 32'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    irq_needs_flag_a: assert property (brownoutIrq |-> brownoutFlag)
        else $error("irq without flag");
    event_sets_flag_a: assert property (brownoutEvent |-> brownoutFlag)
        else $error("event without flag");
    event_single_a: assert property (brownoutEvent |=> !brownoutEvent)
        else $error("event longer than one cycle");
    event_cause_a: assert property (brownoutEvent |-> $past(detectorOut && detectorEnable))
        else $error("event without powered detector");
    fast_source_a: assert property (filterOnSystemClock |-> fastClockSource && !powerDown)
        else $error("filter on system clock in wrong setup");
    reset_filter_a: assert property ($fell(reset) |->
        filterOnSystemClock == (fastClockSource && !powerDown))
        else $error("filter source wrong after reset");
    reset_on_a: assert property ($fell(reset) |-> detectorEnable && !brownoutFlag)
        else $error("detector off after reset");
    off_bounded_a: assert property (offCnt_reg < 32'(OFF_MAX))
        else $error("detector off too long");
    wake_hold_a: assert property ($rose(detectorEnable) |-> detectorEnable [*8])
        else $error("wake too short");
    cover property (brownoutEvent);
    cover property (brownoutIrq);
    cover property ($fell(detectorEnable));
endmodule : brownout_detect_control_checker
bind brownout_detect_control brownout_detect_control_checker #(
    .LP_BASE_PERIOD(LP_BASE_PERIOD), .LOW_SPEED_INTERNAL_OSC_PERIOD(LOW_SPEED_INTERNAL_OSC_PERIOD)) portCheck (.mclk(mclk),
    .reset(reset), .detectorOut(detectorOut), .fastClockSource(fastClockSource),
    .powerDown(powerDown), .detectorEnable(detectorEnable),
    .filterOnSystemClock(filterOnSystemClock), .brownoutEvent(brownoutEvent),
    .brownoutFlag(brownoutFlag), .brownoutIrq(brownoutIrq));

/* test/brownout_detect_control_tb.sv */
// Purpose: self-checking bench for the brown-out control block
// Assumes: shortened periods, base 40 and slow tick 5 system clocks
// Notes:   one task per scenario, registers reached over the plain port
`timescale 1ns/10ps
module brownout_detect_control_tb;
    import brownout_pkg::*;
    localparam int LPB = 40;
    logic       mclk = 1'b0, reset, regWrite, regRead, supplyLow, fastClockSource, powerDown;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       detectorOut, detectorEnable, filterOnSystemClock;
    logic       brownoutEvent, brownoutFlag, brownoutIrq;
    int         errorCnt = 0, nTests = 0, k;
    always #2 mclk = !mclk;
    brownout_detect_control #(.LP_BASE_PERIOD(LPB), .LOW_SPEED_INTERNAL_OSC_PERIOD(5)) dut (.mclk(mclk),
        .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .detectorOut(detectorOut),
        .fastClockSource(fastClockSource), .powerDown(powerDown),
        .detectorEnable(detectorEnable), .filterOnSystemClock(filterOnSystemClock),
        .brownoutEvent(brownoutEvent), .brownoutFlag(brownoutFlag), .brownoutIrq(brownoutIrq));
    brownout_analog_model analog (.mclk(mclk), .detectorEnable(detectorEnable),
        .supplyLow(supplyLow), .detectorOut(detectorOut));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 chk(regRdData, exp);
        @(posedge mclk);
    endtask : rd
    // the key pair must come fresh before every control write
    task automatic wr_ctrl(input logic [7:0] d);
        wr(UNLOCK_OFFSET, UNLOCK_KEY1);
        wr(UNLOCK_OFFSET, UNLOCK_KEY2);
        wr(CTRL_OFFSET, d);
    endtask : wr_ctrl
    // hold the supply low up to n edges; at is the edge the event showed on
    task automatic hold_low(input int n, output int at);
        supplyLow <= 1'b1;
        at = 0;
        for (int i = 1; i <= n && at == 0; i++) begin
            @(posedge mclk);
            #1 if (brownoutEvent === 1'b1) at = i;
        end
        supplyLow <= 1'b0;
        @(posedge mclk);
    endtask : hold_low
    task automatic t_reset();
        rd(CTRL_OFFSET, 8'h01);
        chk(detectorEnable, 1'b1);
        rd(8'h10, 8'h00);
        wr(CTRL_OFFSET, 8'h06);
        rd(CTRL_OFFSET, 8'h01);
        wr(UNLOCK_OFFSET, UNLOCK_KEY1);
        wr(UNLOCK_OFFSET, UNLOCK_KEY2);
        rd(UNLOCK_OFFSET, 8'h01);
        repeat (2) @(posedge mclk);
        wr(CTRL_OFFSET, 8'h06);
        rd(CTRL_OFFSET, 8'h01);
        $display("test reset and lock done");
    endtask : t_reset
    task automatic t_fast();
        chk(filterOnSystemClock, 1'b1);
        hold_low(31, k);
        chk(k[15:0], 16'h0);
        hold_low(40, k);
        chk(k[15:0], 16'd32);
        wr(STATUS_OFFSET, 8'h06);
        chk({brownoutFlag, brownoutIrq}, 2'b11);
        rd(STATUS_OFFSET, 8'h07);
        wr(STATUS_OFFSET, 8'h02);
        chk({brownoutFlag, brownoutIrq}, 2'b10);
        wr(STATUS_OFFSET, 8'h04);
        chk({brownoutFlag, brownoutIrq}, 2'b10);
        wr(STATUS_OFFSET, 8'h01);
        chk(brownoutFlag, 1'b0);
        $display("test fast filter done");
    endtask : t_fast
    task automatic t_bypass();
        wr_ctrl(8'h00);
        rd(CTRL_OFFSET, 8'h00);
        hold_low(10, k);
        chk(k[15:0], 16'h1);
        wr(STATUS_OFFSET, 8'h01);
        powerDown <= 1'b1;
        hold_low(20, k);
        chk(k >= 5 && k <= 11, 1'b1);
        powerDown <= 1'b0;
        wr(STATUS_OFFSET, 8'h01);
        $display("test bypass done");
    endtask : t_bypass
    task automatic t_slow();
        wr_ctrl(8'h01);
        fastClockSource <= 1'b0;
        hold_low(20, k);
        chk(k >= 5 && k <= 11, 1'b1);
        powerDown <= 1'b1;
        fastClockSource <= 1'b1;
        hold_low(20, k);
        chk({filterOnSystemClock, k >= 5 && k <= 11}, 2'b01);
        powerDown <= 1'b0;
        wr(STATUS_OFFSET, 8'h01);
        $display("test slow filter done");
    endtask : t_slow
    // the second rise-to-rise span is clear of any early wake after a mode change
    task automatic t_lowpower();
        logic p;
        for (int m = 1; m <= 3; m++) begin
            wr_ctrl({5'h00, 2'(m), 1'b1});
            chk(filterOnSystemClock, 1'b0);
            for (int r = 0; r < 3; r++) begin
                k = 0;
                do begin
                    p = detectorEnable;
                    @(posedge mclk);
                    #1 k++;
                end while (!(detectorEnable && !p) && k < 2000);
            end
            chk(k[15:0], 16'(LPB << (2 * (m - 1))));
        end
        wr_ctrl(8'h01);
        chk(detectorEnable, 1'b1);
        $display("test low power done");
    endtask : t_lowpower
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // watchdog: the whole sequence needs at most some 2700 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        errorCnt++;
        report_and_stop();
    end
    initial begin
        {reset, regAddr, regWrData, regWrite, regRead, supplyLow, powerDown} = 21'h100000;
        fastClockSource = 1'b1;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_fast();
        t_bypass();
        t_slow();
        t_lowpower();
        report_and_stop();
    end
endmodule : brownout_detect_control_tb
